//--- hw/ctsa_pkg.sv
package ctsa_pkg;

	// clock and timer step
	localparam int CTSA_CLOCK_KHZ     = 20000;
	localparam int CTSA_STEP_TIME_US  = 5000;
	localparam int CTSA_STEP_CYCLES   = CTSA_STEP_TIME_US * CTSA_CLOCK_KHZ
		/ 1000;

	// value widths
	localparam int CTSA_MAG_W   = 16;
	localparam int CTSA_PHZ_W   = 16;
	localparam int CTSA_DIFF_W  = CTSA_PHZ_W + 1;
	localparam int CTSA_DELAY_W = 19;
	localparam int CTSA_CMP_W   = 48;

	// hysteresis and ratio scaling
	localparam logic [47:0] CTSA_PCT_FULL   = 48'h0000_0000_0064;
	localparam logic [47:0] CTSA_HYST_OVER  = 48'h0000_0000_0061;
	localparam logic [47:0] CTSA_HYST_UNDER = 48'h0000_0000_0067;
	localparam logic [47:0] CTSA_RATIO_FULL = 48'h0000_0000_2710;

	// register byte offsets
	localparam logic [7:0] CTSA_OFS_CTRL    = 8'h00;
	localparam logic [7:0] CTSA_OFS_HIGH    = 8'h04;
	localparam logic [7:0] CTSA_OFS_LOW     = 8'h08;
	localparam logic [7:0] CTSA_OFS_MINMAX  = 8'h0C;
	localparam logic [7:0] CTSA_OFS_SEQ     = 8'h10;
	localparam logic [7:0] CTSA_OFS_RESID   = 8'h14;
	localparam logic [7:0] CTSA_OFS_DELAY   = 8'h18;
	localparam logic [7:0] CTSA_OFS_STATUS  = 8'h1C;
	localparam logic [7:0] CTSA_OFS_MAGDIF  = 8'h20;
	localparam logic [7:0] CTSA_OFS_ANGDIF  = 8'h24;

	// control field positions
	localparam int CTSA_CTRL_SEL_LSB = 0;
	localparam int CTSA_CTRL_POL_BIT = 2;

	// reset values: limits in 0.01 In, ratios in 0.01 %, delay in 5 ms
	localparam logic [15:0] CTSA_RST_HIGH   = 16'h0078;
	localparam logic [15:0] CTSA_RST_LOW    = 16'h000A;
	localparam logic [15:0] CTSA_RST_MINMAX = 16'h03E8;
	localparam logic [15:0] CTSA_RST_SEQ    = 16'h1324;
	localparam logic [15:0] CTSA_RST_RESID  = 16'h000A;
	localparam logic [18:0] CTSA_RST_DELAY  = 19'h00064;

	// residual source choice
	typedef enum logic [1:0] {
		CTSA_RES_NONE = 2'b00,
		CTSA_RES_CH1  = 2'b01,
		CTSA_RES_CH2  = 2'b10
	} ctsa_res_sel_type;

	// supervision states
	typedef enum logic [1:0] {
		CTSA_ST_IDLE  = 2'b00,
		CTSA_ST_START = 2'b01,
		CTSA_ST_ALARM = 2'b10,
		CTSA_ST_BLOCK = 2'b11
	} ctsa_state_type;

	// measured magnitudes from the front end
	typedef struct packed {
		logic [2:0][15:0] phase;
		logic [15:0]      pos_seq;
		logic [15:0]      neg_seq;
	} ctsa_meas_type;

	// phasor in rectangular form, 0.01 In per lsb
	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} ctsa_phasor_type;

	// function outputs
	typedef struct packed {
		logic alarm;
		logic blocked;
		logic start;
	} ctsa_status_type;

endpackage : ctsa_pkg

//--- hw/ctsa_isqrt.sv
`timescale 1ns/1ps
`default_nettype none
module ctsa_isqrt #(
	parameter int W = 17
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         reset_n,
	// operand and result
	input  wire logic         go,
	input  wire logic [2*W-1:0] radicand,
	output logic [W-1:0]      root,
	output logic              done
);
	localparam int CW = $clog2(W + 1);
	localparam logic [CW-1:0] CNT_INIT = CW'(W);
	localparam logic [CW-1:0] CNT_LAST = CW'(1);

	logic [2*W-1:0] x_q;
	logic [W-1:0]   acc_q;
	logic [W+2:0]   rem_q;
	logic [CW-1:0]  cnt_q;
	logic [W+2:0]   rem_sh;
	logic [W+2:0]   trial;
	logic           fits;

	// one digit of the restoring square root per clock
	assign rem_sh = {rem_q[W:0], x_q[2*W-1 -: 2]};
	assign trial  = {1'b0, acc_q, 2'b01};
	assign fits   = rem_sh >= trial;

	// iteration state
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			x_q   <= '0;
			acc_q <= '0;
			rem_q <= '0;
			cnt_q <= '0;
		end else if (go) begin
			x_q   <= radicand;
			acc_q <= '0;
			rem_q <= '0;
			cnt_q <= CNT_INIT;
		end else if (cnt_q != '0) begin
			x_q   <= {x_q[2*W-3:0], 2'b00};
			rem_q <= fits ? rem_sh - trial : rem_sh;
			acc_q <= {acc_q[W-2:0], fits};
			cnt_q <= cnt_q - CNT_LAST;
		end
	end

	// result register and completion pulse
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			root <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!go && cnt_q == CNT_LAST) begin
				root <= {acc_q[W-2:0], fits};
				done <= 1'b1;
			end
		end
	end
endmodule : ctsa_isqrt
`default_nettype wire

//--- hw/ctsa_supervision.sv
// Behaviour
// - over limits release at 97 %, under limits at 103 % of setting
// - one threshold for all phases; any one, two or three may pick up
// - any phase above the high limit means fault; no activation
// - need one phase above and one phase below the low limit
// - min/max phase ratio must be below the ratio limit
// - negative/positive sequence ratio must exceed its limit
// - with residual selected, sum-residual mismatch must exceed limit
// - alarm only after conditions persist for the definite delay
// - blocking input sampled once at each program cycle start
// - unblocked pick-up raises start and begins delay timing
// - blocked pick-up raises blocked, no timing, no alarm
// - blocking during start clears start like a drop-out
// - delay is fixed, independent of current magnitudes
// - settings may change live and take effect at once
// - mismatch magnitude and angle difference are readable
// - all conditions are ANDed; residual term only when selected
// - residual source none/ch1/ch2, polarity add or subtract
`timescale 1ns/1ps
`default_nettype none
module ctsa_supervision
	import ctsa_pkg::*;
#(
	parameter int STEP_CYCLES = CTSA_STEP_CYCLES
) (
	// clock and reset
	input  wire logic            clock,
	input  wire logic            reset_n,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// measurement front end
	input  wire logic            cycle_tick,
	input  wire ctsa_meas_type   meas,
	input  wire ctsa_phasor_type phase_sum,
	input  wire ctsa_phasor_type residual1,
	input  wire ctsa_phasor_type residual2,
	input  wire logic [15:0]     sum_angle,
	input  wire logic [15:0]     residual1_angle,
	input  wire logic [15:0]     residual2_angle,
	// blocking matrix
	input  wire logic            blocking,
	// function outputs
	output ctsa_status_type      status
);
	localparam int PW = $clog2(STEP_CYCLES);
	localparam logic [PW-1:0] PRE_LAST = PW'(STEP_CYCLES - 1);
	localparam logic [PW-1:0] PRE_ONE  = PW'(1);
	localparam logic [CTSA_DELAY_W-1:0] STEP_ONE = CTSA_DELAY_W'(1);

	// settings
	ctsa_res_sel_type residual_source_select;
	logic                    residual_polarity;
	logic [15:0]             high_q, low_q, minmax_q, seq_q, resid_q;
	logic [CTSA_DELAY_W-1:0] definite_delay;
	// comparison flags and state
	logic [2:0]              high_q3, lo_over_q, lo_under_q;
	logic [2:0]              high_d3, lo_over_d, lo_under_d;
	logic                    ratio_q, seq_flag_q, resid_flag_q;
	logic                    ratio_d, seq_flag_d, resid_flag_d;
	logic                    block_q, pickup_d, expired;
	ctsa_state_type          state_q, state_d;
	logic [PW-1:0]           pre_q;
	logic [CTSA_DELAY_W-1:0] steps_q;
	// mismatch path
	logic signed [CTSA_DIFF_W-1:0] diff_re, diff_im;
	logic signed [15:0]      res_re, res_im;
	logic [15:0]             res_ang;
	logic [2*CTSA_DIFF_W-1:0] diff_sq;
	logic [CTSA_DIFF_W-1:0]  mag_diff;
	logic signed [16:0]      ang_diff_q;
	logic                    sqrt_done;
	logic [15:0]             mmin, mmax;
	logic                    res_on;
	// bus
	logic                    wr_en, rd_setup, mapped;

	// hysteresis comparators: set beyond limit, release past 97/103 %
	function automatic logic over_next(input logic st,
		input logic [47:0] a, input logic [47:0] l);
		over_next = st ? (a * CTSA_PCT_FULL >= l * CTSA_HYST_OVER)
			: (a > l);
	endfunction : over_next

	function automatic logic under_next(input logic st,
		input logic [47:0] a, input logic [47:0] l);
		under_next = st ? (a * CTSA_PCT_FULL <= l * CTSA_HYST_UNDER)
			: (a < l);
	endfunction : under_next

	// per-phase limit checks, common thresholds
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_phase
			assign high_d3[gi] = over_next(high_q3[gi],
				48'(meas.phase[gi]), 48'(high_q));
			assign lo_over_d[gi] = over_next(lo_over_q[gi],
				48'(meas.phase[gi]), 48'(low_q));
			assign lo_under_d[gi] = under_next(lo_under_q[gi],
				48'(meas.phase[gi]), 48'(low_q));
			always_ff @(posedge clock) begin
				if (!reset_n) begin
					high_q3[gi]    <= 1'b0;
					lo_over_q[gi]  <= 1'b0;
					lo_under_q[gi] <= 1'b0;
				end else if (cycle_tick) begin
					high_q3[gi]    <= high_d3[gi];
					lo_over_q[gi]  <= lo_over_d[gi];
					lo_under_q[gi] <= lo_under_d[gi];
				end
			end
		end
	endgenerate

	// minimum and maximum phase magnitude
	always_comb begin
		mmin = meas.phase[0];
		mmax = meas.phase[0];
		for (int k = 1; k < 3; k++) begin
			if (meas.phase[k] < mmin) mmin = meas.phase[k];
			if (meas.phase[k] > mmax) mmax = meas.phase[k];
		end
	end

	// ratio checks, cross-multiplied against the 100.00 % scale; mismatch checked directly against its limit
	assign ratio_d = under_next(ratio_q, 48'(mmin) * CTSA_RATIO_FULL,
		48'(minmax_q) * 48'(mmax));
	assign seq_flag_d = over_next(seq_flag_q,
		48'(meas.neg_seq) * CTSA_RATIO_FULL,
		48'(seq_q) * 48'(meas.pos_seq));
	assign resid_flag_d = over_next(resid_flag_q, 48'(mag_diff),
		48'(resid_q));

	// residual channel selection and polarity
	always_comb begin
		unique case (residual_source_select)
			CTSA_RES_CH1: begin
				res_re  = residual1.re;
				res_im  = residual1.im;
				res_ang = residual1_angle;
			end
			CTSA_RES_CH2: begin
				res_re  = residual2.re;
				res_im  = residual2.im;
				res_ang = residual2_angle;
			end
			default: begin
				res_re  = '0;
				res_im  = '0;
				res_ang = sum_angle;
			end
		endcase
	end
	assign res_on  = residual_source_select != CTSA_RES_NONE;
	assign diff_re = residual_polarity
		? CTSA_DIFF_W'(phase_sum.re) - CTSA_DIFF_W'(res_re)
		: CTSA_DIFF_W'(phase_sum.re) + CTSA_DIFF_W'(res_re);
	assign diff_im = residual_polarity
		? CTSA_DIFF_W'(phase_sum.im) - CTSA_DIFF_W'(res_im)
		: CTSA_DIFF_W'(phase_sum.im) + CTSA_DIFF_W'(res_im);
	assign diff_sq = $unsigned((2*CTSA_DIFF_W)'(diff_re)
		* (2*CTSA_DIFF_W)'(diff_re))
		+ $unsigned((2*CTSA_DIFF_W)'(diff_im)
		* (2*CTSA_DIFF_W)'(diff_im));

	// mismatch magnitude, refreshed once per program cycle
	ctsa_isqrt #(
		.W (CTSA_DIFF_W)
	) u_isqrt (
		.clock    (clock),
		.reset_n  (reset_n),
		.go       (cycle_tick),
		.radicand (diff_sq),
		.root     (mag_diff),
		.done     (sqrt_done)
	);

	// angle difference readout
	always_ff @(posedge clock) begin
		if (!reset_n) ang_diff_q <= '0;
		else if (sqrt_done)
			ang_diff_q <= 17'(sum_angle) - 17'(res_ang);
	end

	// unbalance flags and blocking sample at program cycle start
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ratio_q      <= 1'b0;
			seq_flag_q   <= 1'b0;
			resid_flag_q <= 1'b0;
			block_q      <= 1'b0;
		end else if (cycle_tick) begin
			ratio_q      <= ratio_d;
			seq_flag_q   <= seq_flag_d;
			resid_flag_q <= resid_flag_d;
			block_q      <= blocking;
		end
	end

	// all activation terms together
	assign pickup_d = ~|high_d3 && |lo_over_d && |lo_under_d
		&& ratio_d && seq_flag_d
		&& (!res_on || resid_flag_d);

	// definite delay in 5 ms steps, blind to magnitudes
	assign expired = steps_q >= definite_delay;
	always_ff @(posedge clock) begin
		if (!reset_n || state_q != CTSA_ST_START) begin
			pre_q   <= '0;
			steps_q <= '0;
		end else if (pre_q == PRE_LAST) begin
			pre_q <= '0;
			if (!expired) steps_q <= steps_q + STEP_ONE;
		end else begin
			pre_q <= pre_q + PRE_ONE;
		end
	end

	// start, blocked and alarm sequencing
	always_comb begin
		state_d = state_q;
		if (cycle_tick && !pickup_d)
			state_d = CTSA_ST_IDLE;
		else if (cycle_tick && blocking)
			state_d = CTSA_ST_BLOCK;
		else if (cycle_tick && state_q == CTSA_ST_BLOCK)
			state_d = CTSA_ST_START;
		else if (cycle_tick && state_q == CTSA_ST_IDLE)
			state_d = CTSA_ST_START;
		else if (state_q == CTSA_ST_START && expired)
			state_d = CTSA_ST_ALARM;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q <= CTSA_ST_IDLE;
			status  <= '0;
		end else begin
			state_q        <= state_d;
			status.start   <= state_d == CTSA_ST_START
				|| state_d == CTSA_ST_ALARM;
			status.alarm   <= state_d == CTSA_ST_ALARM;
			status.blocked <= state_d == CTSA_ST_BLOCK;
		end
	end

	// apb decode, zero wait states
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign pready   = 1'b1;
	always_comb begin
		unique case (paddr)
			CTSA_OFS_CTRL, CTSA_OFS_HIGH, CTSA_OFS_LOW, CTSA_OFS_MINMAX,
			CTSA_OFS_SEQ, CTSA_OFS_RESID, CTSA_OFS_DELAY, CTSA_OFS_STATUS,
			CTSA_OFS_MAGDIF, CTSA_OFS_ANGDIF: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !mapped;

	// setting registers, writable while running
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			residual_source_select <= CTSA_RES_NONE;
			residual_polarity      <= 1'b0;
			high_q         <= CTSA_RST_HIGH;
			low_q          <= CTSA_RST_LOW;
			minmax_q       <= CTSA_RST_MINMAX;
			seq_q          <= CTSA_RST_SEQ;
			resid_q        <= CTSA_RST_RESID;
			definite_delay <= CTSA_RST_DELAY;
		end else if (wr_en) begin
			unique case (paddr)
				CTSA_OFS_CTRL: begin
					residual_source_select <= (pwdata[CTSA_CTRL_SEL_LSB +: 2]
						== 2'h3) ? CTSA_RES_NONE
						: ctsa_res_sel_type'(pwdata[CTSA_CTRL_SEL_LSB +: 2]);
					residual_polarity <= pwdata[CTSA_CTRL_POL_BIT];
				end
				CTSA_OFS_HIGH:   high_q   <= pwdata[15:0];
				CTSA_OFS_LOW:    low_q    <= pwdata[15:0];
				CTSA_OFS_MINMAX: minmax_q <= pwdata[15:0];
				CTSA_OFS_SEQ:    seq_q    <= pwdata[15:0];
				CTSA_OFS_RESID:  resid_q  <= pwdata[15:0];
				CTSA_OFS_DELAY:  definite_delay <= pwdata[CTSA_DELAY_W-1:0];
				default: ;
			endcase
		end
	end

	// read data loaded in the setup phase
	always_ff @(posedge clock) begin
		if (!reset_n) prdata <= '0;
		else if (rd_setup) begin
			unique case (paddr)
				CTSA_OFS_CTRL: prdata <= {29'h0, residual_polarity,
					residual_source_select};
				CTSA_OFS_HIGH:   prdata <= {16'h0, high_q};
				CTSA_OFS_LOW:    prdata <= {16'h0, low_q};
				CTSA_OFS_MINMAX: prdata <= {16'h0, minmax_q};
				CTSA_OFS_SEQ:    prdata <= {16'h0, seq_q};
				CTSA_OFS_RESID:  prdata <= {16'h0, resid_q};
				CTSA_OFS_DELAY:  prdata <= {13'h0, definite_delay};
				CTSA_OFS_STATUS: prdata <= {26'h0, block_q, resid_flag_q,
					seq_flag_q, ratio_q, state_q};
				CTSA_OFS_MAGDIF: prdata <= {15'h0, mag_diff};
				CTSA_OFS_ANGDIF: prdata <= {15'h0, ang_diff_q};
				default:         prdata <= '0;
			endcase
		end
	end

	// checks
	property p_start_unblocked;
		@(posedge clock) disable iff (!reset_n)
		$rose(status.start) |-> $past(cycle_tick) && !block_q;
	endproperty
	a_start_unblocked: assert property (p_start_unblocked)
		else $error("start rose without unblocked tick");

	property p_block_pickup;
		@(posedge clock) disable iff (!reset_n)
		cycle_tick && pickup_d && blocking
			|=> status.blocked && !status.start && !status.alarm;
	endproperty
	a_block_pickup: assert property (p_block_pickup)
		else $error("blocked pick-up not reported as blocked");

	property p_block_release;
		@(posedge clock) disable iff (!reset_n)
		status.start && cycle_tick && blocking
			|=> !status.start ##1 steps_q == '0;
	endproperty
	a_block_release: assert property (p_block_release)
		else $error("start kept running under blocking");

	property p_dropout;
		@(posedge clock) disable iff (!reset_n)
		cycle_tick && !pickup_d |=> !status.alarm && !status.start
			##1 steps_q == '0;
	endproperty
	a_dropout: assert property (p_dropout)
		else $error("drop-out did not clear start and alarm");

	property p_alarm_delay;
		@(posedge clock) disable iff (!reset_n)
		$rose(status.alarm) |-> $past(expired) && $past(status.start);
	endproperty
	a_alarm_delay: assert property (p_alarm_delay)
		else $error("alarm before the definite delay ran out");

	property p_high_fault;
		@(posedge clock) disable iff (!reset_n)
		cycle_tick && |high_d3 |=> !status.start && !status.blocked;
	endproperty
	a_high_fault: assert property (p_high_fault)
		else $error("activation despite phase above high limit");

	property p_hysteresis;
		@(posedge clock) disable iff (!reset_n)
		cycle_tick && high_q3[1] && 48'(meas.phase[1]) * CTSA_PCT_FULL
			>= 48'(high_q) * CTSA_HYST_OVER |=> high_q3[1];
	endproperty
	a_hysteresis: assert property (p_hysteresis)
		else $error("over flag released inside hysteresis band");

	property p_and_start;
		@(posedge clock) disable iff (!reset_n)
		cycle_tick && pickup_d && !blocking && state_q == CTSA_ST_IDLE
			|=> status.start ##0 state_q == CTSA_ST_START;
	endproperty
	a_and_start: assert property (p_and_start)
		else $error("all terms held but start not raised");
endmodule : ctsa_supervision
`default_nettype wire

//--- test/ctsa_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctsa_front_model
	import ctsa_pkg::*;
#(
	parameter int GAP = 32
) (
	// clock and reset
	input  wire logic            clock,
	input  wire logic            reset_n,
	// values asked for by the bench
	input  wire ctsa_meas_type   meas_req,
	input  wire ctsa_phasor_type res1_req,
	input  wire logic            block_req,
	// towards the supervision block
	output logic                 cycle_tick,
	output ctsa_meas_type        meas,
	output ctsa_phasor_type      residual1,
	output logic                 blocking
);
	logic [7:0] cnt_q;

	// program cycle counter and its tick
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_q      <= 8'h00;
			cycle_tick <= 1'b0;
		end else begin
			cnt_q      <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
			cycle_tick <= (cnt_q == 8'(GAP - 2));
		end
	end

	// new values land just after a tick, a whole cycle ahead
	always_ff @(posedge clock) begin
		if (cnt_q == 8'h00) begin
			meas      <= meas_req;
			residual1 <= res1_req;
			blocking  <= block_req;
		end
	end
endmodule : ctsa_front_model
`default_nettype wire

//--- test/ctsa_supervision_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
	end \
end
module ctsa_supervision_bench
	import ctsa_pkg::*;
;
	localparam int STEP = 4; // shortened 5 ms step
	localparam int DLY  = 20; // alarm delay in steps
	localparam ctsa_meas_type FLT = 80'h0064_0064_0000_0043_0021;
	localparam ctsa_meas_type HLT = 80'h0064_0064_0064_0064_0000;
	localparam logic [7:0] OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
		8'h14, 8'h18};
	localparam logic [31:0] DFL [7] = '{32'h0, 32'h78, 32'hA, 32'h3E8,
		32'h1324, 32'hA, 32'h64};
	logic            clock, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]      paddr, ta [16];
	logic [31:0]     pwdata, prdata, rd_v, td [16];
	logic [15:0]     tr [16];
	logic            er_v, cycle_tick, blocking, block_req, te [16];
	ctsa_meas_type   meas, meas_req, tm [16];
	ctsa_phasor_type residual1, res1_req, phase_sum;
	ctsa_status_type status;
	int              n_mismatch, n_compared, cyc;

	// far side: tick, measurements and blocking
	ctsa_front_model #(.GAP(32)) model (.clock(clock), .reset_n(reset_n),
		.meas_req(meas_req), .res1_req(res1_req), .block_req(block_req),
		.cycle_tick(cycle_tick), .meas(meas), .residual1(residual1),
		.blocking(blocking));

	ctsa_supervision #(.STEP_CYCLES(STEP)) dut (.clock(clock),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cycle_tick(cycle_tick), .meas(meas),
		.phase_sum(phase_sum), .residual1(residual1),
		.residual2(32'h0000_0000), .sum_angle(16'h2328),
		.residual1_angle(16'h0000), .residual2_angle(16'h0BB8),
		.blocking(blocking), .status(status));

	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd_v = prdata;
		er_v = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// wait n ticks, then let the status settle
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clock);
			while (cycle_tick !== 1'b1) @(posedge clock);
		end
		@(posedge clock);
		#1;
	endtask : step

	task automatic setm(input ctsa_meas_type m, input logic b);
		@(posedge clock);
		meas_req  <= m;
		block_req <= b;
	endtask : setm

	task automatic pick(input ctsa_meas_type m);
		setm(m, 1'b0);
		step(2);
	endtask : pick

	// cycles from start rising to alarm rising
	task automatic alarm_time();
		int n;
		n = 0;
		while (status.start !== 1'b1 && n < 200) begin
			@(posedge clock);
			#1;
			n++;
		end
		n = 0;
		while (status.alarm !== 1'b1 && n < 400) begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("alarm delay", DLY * STEP + 1, n)
	endtask : alarm_time

	function automatic ctsa_meas_type mk(input logic [15:0] a, b, c,
		input logic [15:0] p = 16'h0043, q = 16'h0021);
		mk = {c, b, a, p, q};
	endfunction : mk

	initial begin
		psel      <= 1'b0;
		penable   <= 1'b0;
		pwrite    <= 1'b0;
		paddr     <= 8'h00;
		pwdata    <= 32'h0;
		reset_n   <= 1'b0;
		meas_req  <= HLT;
		res1_req  <= 32'h0;
		phase_sum <= 32'h0064_0000;
		block_req <= 1'b0;
		ta = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h0C, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		td = '{32'h0, 32'h0, 32'h0, 32'h8C, 32'h78, 32'h0, 32'h0, 32'h0,
			32'h0, 32'h320, 32'h3E8, 32'h0, 32'h1, 32'h1, 32'h5, 32'h2};
		tr = '{16'hFF9C, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
			16'h0, 16'h0, 16'h0, 16'h0, 16'hFF9C, 16'h0, 16'h64, 16'h64};
		te = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
			1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		tm = '{FLT, mk(16'h0, 16'h0, 16'h64), mk(16'h0, 16'h82, 16'h64),
			mk(16'h0, 16'h82, 16'h64), mk(16'h0, 16'h79, 16'h64),
			mk(16'h0, 16'h76, 16'h64), mk(16'h0, 16'h74, 16'h64),
			mk(16'h0, 16'h8, 16'h8), mk(16'h9, 16'h3C, 16'h64),
			mk(16'h9, 16'h3C, 16'h64), mk(16'h0, 16'h64, 16'h64, 16'h64,
			16'h28), mk(16'h0, 16'h64, 16'h64, 16'h64, 16'h32),
			FLT, FLT, FLT, FLT};
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		// settings come up at their defaults
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, OFS[i], 32'h0);
			`CHK("reset value", DFL[i], rd_v)
		end
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped error", 1'b1, er_v)
		`CHK("unmapped data", 32'h0, rd_v)
		apb(1'b1, 8'h18, DLY);
		$display("test defaults done");
		// pick-up, drop-out and definite delay
		pick(FLT);
		`CHK("status", 3'b001, status)
		pick(HLT);
		`CHK("status", 3'b000, status)
		setm(FLT, 1'b0);
		alarm_time();
		pick(HLT);
		`CHK("status", 3'b000, status)
		setm(mk(16'h0, 16'h6E, 16'h6E, 16'h49, 16'h24), 1'b0);
		alarm_time();
		$display("test timing done");
		// blocking taken only at the program cycle start
		setm(FLT, 1'b1);
		step(1);
		`CHK("status", 3'b101, status)
		step(1);
		`CHK("status", 3'b010, status)
		step(4);
		`CHK("status", 3'b010, status)
		setm(FLT, 1'b0);
		alarm_time();
		$display("test blocking done");
		// activation conditions one by one, settings changed live
		apb(1'b1, 8'h18, 32'hC8);
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, ta[i], td[i]);
			@(posedge clock);
			res1_req <= {tr[i], 16'h0000};
			meas_req <= tm[i];
			step(3);
			`CHK("start", te[i], status.start)
		end
		apb(1'b0, 8'h20, 32'h0);
		`CHK("magnitude difference", 32'h64, rd_v)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("angle difference", 32'h1770, rd_v)
		apb(1'b1, 8'h00, 32'h3);
		apb(1'b0, 8'h00, 32'h0);
		`CHK("refused select", 32'h0, rd_v)
		$display("test conditions done");
		end_sim();
	end
endmodule : ctsa_supervision_bench
`default_nettype wire
